// file: hw/sie_top.sv
// The address map and the AXI4-Lite slave port were left to the implementer.
`timescale 1ns/1ps
`include "sie_defines.svh"

// Behaviour
// - The literal subtract takes the accumulator from the 8-bit literal and puts it back in the accumulator.
// - The literal subtract is recognised by an upper opcode byte of 0000 1000, the low byte being the literal.
// - The literal subtract always writes the accumulator and never a file register.
// - Opcode 0101 11da computes the addressed file register minus the accumulator in two's complement.
// - A destination bit of 0 sends the file subtract result to the accumulator, 1 to the file register.
// - Access bit 0 takes the operand from the access bank, 1 takes it from the bank named by the bank pointer.
// - Access bit 0 with the extended set on and an address of at most 95 uses indexed literal offset addressing.
// - A negative result clears the carry/borrow flag and sets the negative flag.
// - A zero result sets the zero and carry/borrow flags and clears the negative flag.
// - A negative difference is kept as its 8-bit two's complement, so 2 minus 3 gives ffh.
// - The reverse subtract with carry clear takes one more off, and a zero outcome sets zero and carry.
// - Opcode 0101 01da computes accumulator minus file register minus inverted carry into the chosen target.
module sie_top import sie_pkg::*; #(
   parameter int AXI_AW = 8,
   parameter int BANK_W = 4
) (
   // Clock and reset
   input  wire logic              aclk,
   input  wire logic              aresetn,
   // Write address channel
   input  wire logic [AXI_AW-1:0] s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   // Write data channel
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   // Write response channel
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   // Read address channel
   input  wire logic [AXI_AW-1:0] s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   // Read data channel
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready
);

   localparam int AW    = BANK_W + 8;
   localparam int DEPTH = 1 << AW;

   if (AXI_AW < 8 || AXI_AW > 32) begin : g_bad_aw
      $error("AXI_AW must lie in 8..32");
   end
   if (BANK_W < 1 || BANK_W > 8) begin : g_bad_bank
      $error("BANK_W must lie in 1..8");
   end

   function automatic logic mapped(input logic [7:0] a);
      mapped = (a == `SIE_OFF_CTRL)     || (a == `SIE_OFF_INSTR)    ||
               (a == `SIE_OFF_ACC)      || (a == `SIE_OFF_BANK)     ||
               (a == `SIE_OFF_STATUS)   || (a == `SIE_OFF_INDEX)    ||
               (a == `SIE_OFF_MEM_ADDR) || (a == `SIE_OFF_MEM_DATA);
   endfunction : mapped

   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] data,
                                         input logic [3:0]  strb);
      for (int i = 0; i < 4; i++) begin
         old[i*8 +: 8] = strb[i] ? data[i*8 +: 8] : old[i*8 +: 8];
      end
      merge = old;
   endfunction : merge

   // Bus state
   sie_wr_state_t     wr_state_reg,  wr_state_next;
   sie_rd_state_t     rd_state_reg,  rd_state_next;
   logic              aw_hold_reg,   aw_hold_next;
   logic              w_hold_reg,    w_hold_next;
   logic [7:0]        wr_addr_reg,   wr_addr_next;
   logic [31:0]       wr_data_reg,   wr_data_next;
   logic [3:0]        wr_strb_reg,   wr_strb_next;
   logic              awready_reg,   awready_next;
   logic              wready_reg,    wready_next;
   logic              bvalid_reg,    bvalid_next;
   logic [1:0]        bresp_reg,     bresp_next;
   logic              arready_reg,   arready_next;
   logic              rvalid_reg,    rvalid_next;
   logic [31:0]       rdata_reg,     rdata_next;
   logic [1:0]        rresp_reg,     rresp_next;

   // Core state
   logic              ext_reg,       ext_next;
   logic [15:0]       instr_reg,     instr_next;
   logic              exec_reg,      exec_next;
   logic [7:0]        acc_reg,       acc_next;
   logic [BANK_W-1:0] bank_reg,      bank_next;
   logic [AW-1:0]     index_reg,     index_next;
   logic [AW-1:0]     mem_addr_reg,  mem_addr_next;
   logic              c_reg,         c_next;
   logic              dc_reg,        dc_next;
   logic              z_reg,         z_next;
   logic              ov_reg,        ov_next;
   logic              n_reg,         n_next;
   logic              ill_reg,       ill_next;

   // File memory
   logic [7:0]        file_mem [0:DEPTH-1];
   logic              mem_we;
   logic [AW-1:0]     mem_waddr;
   logic [7:0]        mem_wdata;

   // Execution datapath
   sie_op_t           op;
   logic              to_file;
   logic [AW-1:0]     file_addr;
   logic [7:0]        file_val;
   logic [7:0]        alu_min;
   logic [7:0]        alu_sub;
   logic              alu_bin;
   logic [7:0]        alu_diff;
   logic              alu_c;
   logic              alu_dc;
   logic              alu_z;
   logic              alu_ov;
   logic              alu_n;
   logic [31:0]       status_word;
   logic [31:0]       merged;

   sie_decode #(
      .BANK_W       (BANK_W)
   ) u_decode (
      .instr        (instr_reg),
      .ext_en       (ext_reg),
      .bank_pointer (bank_reg),
      .index_ptr    (index_reg),
      .op           (op),
      .to_file      (to_file),
      .file_addr    (file_addr)
   );

   assign file_val = file_mem[file_addr];

   always_comb begin
      unique case (op)
         SIE_LITERAL_MINUS_ACCUMULATOR_OP: begin
            alu_min = instr_reg[7:0];
            alu_sub = acc_reg;
            alu_bin = 1'b0;
         end
         SIE_REVERSE_SUBTRACT_WITH_BORROW_OP: begin
            alu_min = acc_reg;
            alu_sub = file_val;
            alu_bin = ~c_reg;
         end
         default: begin
            alu_min = file_val;
            alu_sub = acc_reg;
            alu_bin = 1'b0;
         end
      endcase
   end

   sie_alu u_alu (
      .minuend          (alu_min),
      .subtrahend       (alu_sub),
      .borrow_in        (alu_bin),
      .diff             (alu_diff),
      .carry            (alu_c),
      .half_carry_flag  (alu_dc),
      .zero             (alu_z),
      .signed_wrap_flag (alu_ov),
      .negative         (alu_n)
   );

   assign status_word = {26'h0000000, ill_reg, n_reg, ov_reg, z_reg, dc_reg, c_reg};
   assign merged = merge(32'h00000000, wr_data_reg, wr_strb_reg);

   always_comb begin
      wr_state_next = wr_state_reg;
      rd_state_next = rd_state_reg;
      aw_hold_next  = aw_hold_reg;
      w_hold_next   = w_hold_reg;
      wr_addr_next  = wr_addr_reg;
      wr_data_next  = wr_data_reg;
      wr_strb_next  = wr_strb_reg;
      bvalid_next   = bvalid_reg;
      bresp_next    = bresp_reg;
      rvalid_next   = rvalid_reg;
      rdata_next    = rdata_reg;
      rresp_next    = rresp_reg;
      ext_next      = ext_reg;
      instr_next    = instr_reg;
      exec_next     = 1'b0;
      acc_next      = acc_reg;
      bank_next     = bank_reg;
      index_next    = index_reg;
      mem_addr_next = mem_addr_reg;
      c_next        = c_reg;
      dc_next       = dc_reg;
      z_next        = z_reg;
      ov_next       = ov_reg;
      n_next        = n_reg;
      ill_next      = ill_reg;
      mem_we        = 1'b0;
      mem_waddr     = mem_addr_reg;
      mem_wdata     = 8'h00;

      // Address and data taken in either order
      if (s_axi_awvalid && awready_reg) begin
         aw_hold_next = 1'b1;
         wr_addr_next = s_axi_awaddr[7:0];
      end
      if (s_axi_wvalid && wready_reg) begin
         w_hold_next  = 1'b1;
         wr_data_next = s_axi_wdata;
         wr_strb_next = s_axi_wstrb;
      end

      unique case (wr_state_reg)
         SIE_WR_COLLECT: begin
            if (aw_hold_reg && w_hold_reg) begin
               aw_hold_next  = 1'b0;
               w_hold_next   = 1'b0;
               bvalid_next   = 1'b1;
               bresp_next    = mapped(wr_addr_reg) ? `SIE_RESP_OKAY : `SIE_RESP_SLVERR;
               wr_state_next = SIE_WR_RESP;
               unique case (wr_addr_reg)
                  `SIE_OFF_CTRL: begin
                     if (wr_strb_reg[0]) begin
                        ext_next = wr_data_reg[`SIE_CTRL_EXT_BIT];
                     end
                  end
                  `SIE_OFF_INSTR: begin
                     instr_next = 16'(merge({16'h0000, instr_reg}, wr_data_reg, wr_strb_reg));
                     exec_next  = 1'b1;
                  end
                  `SIE_OFF_ACC: begin
                     acc_next = 8'(merge({24'h000000, acc_reg}, wr_data_reg, wr_strb_reg));
                  end
                  `SIE_OFF_BANK: begin
                     if (wr_strb_reg[0]) begin
                        bank_next = wr_data_reg[BANK_W-1:0];
                     end
                  end
                  `SIE_OFF_STATUS: begin
                     if (wr_strb_reg[0]) begin
                        c_next  = wr_data_reg[`SIE_ST_C_BIT];
                        dc_next = wr_data_reg[`SIE_ST_DC_BIT];
                        z_next  = wr_data_reg[`SIE_ST_Z_BIT];
                        ov_next = wr_data_reg[`SIE_ST_OV_BIT];
                        n_next  = wr_data_reg[`SIE_ST_N_BIT];
                        ill_next = ill_reg & ~wr_data_reg[`SIE_ST_ILL_BIT];
                     end
                  end
                  `SIE_OFF_INDEX: begin
                     index_next = AW'(merge({{(32-AW){1'b0}}, index_reg}, wr_data_reg,
                                            wr_strb_reg));
                  end
                  `SIE_OFF_MEM_ADDR: begin
                     mem_addr_next = AW'(merge({{(32-AW){1'b0}}, mem_addr_reg}, wr_data_reg,
                                               wr_strb_reg));
                  end
                  `SIE_OFF_MEM_DATA: begin
                     mem_we    = wr_strb_reg[0];
                     mem_wdata = merged[7:0];
                  end
                  default: begin
                  end
               endcase
            end
         end
         SIE_WR_RESP: begin
            if (s_axi_bready) begin
               bvalid_next   = 1'b0;
               wr_state_next = SIE_WR_COLLECT;
            end
         end
      endcase

      unique case (rd_state_reg)
         SIE_RD_IDLE: begin
            if (s_axi_arvalid && arready_reg) begin
               rvalid_next   = 1'b1;
               rresp_next    = mapped(s_axi_araddr[7:0]) ? `SIE_RESP_OKAY : `SIE_RESP_SLVERR;
               rd_state_next = SIE_RD_RESP;
               unique case (s_axi_araddr[7:0])
                  `SIE_OFF_CTRL:     rdata_next = {31'h00000000, ext_reg};
                  `SIE_OFF_INSTR:    rdata_next = {16'h0000, instr_reg};
                  `SIE_OFF_ACC:      rdata_next = {24'h000000, acc_reg};
                  `SIE_OFF_BANK:     rdata_next = {{(32-BANK_W){1'b0}}, bank_reg};
                  `SIE_OFF_STATUS:   rdata_next = status_word;
                  `SIE_OFF_INDEX:    rdata_next = {{(32-AW){1'b0}}, index_reg};
                  `SIE_OFF_MEM_ADDR: rdata_next = {{(32-AW){1'b0}}, mem_addr_reg};
                  `SIE_OFF_MEM_DATA: rdata_next = {24'h000000, file_mem[mem_addr_reg]};
                  default:           rdata_next = 32'h00000000;
               endcase
            end
         end
         SIE_RD_RESP: begin
            if (s_axi_rready) begin
               rvalid_next   = 1'b0;
               rd_state_next = SIE_RD_IDLE;
            end
         end
      endcase

      // Instruction executes one cycle after its write
      if (exec_reg) begin
         if (op == SIE_OP_NONE) begin
            ill_next = 1'b1;
         end else begin
            c_next  = alu_c;
            z_next  = alu_z;
            n_next  = alu_n;
            dc_next = alu_dc;
            ov_next = alu_ov;
            if (to_file) begin
               mem_we    = 1'b1;
               mem_waddr = file_addr;
               mem_wdata = alu_diff;
            end else begin
               acc_next = alu_diff;
            end
         end
      end

      awready_next = ~aw_hold_next && (wr_state_next == SIE_WR_COLLECT);
      wready_next  = ~w_hold_next && (wr_state_next == SIE_WR_COLLECT);
      arready_next = (rd_state_next == SIE_RD_IDLE);
   end

   always_ff @(posedge aclk) begin
      if (mem_we) begin
         file_mem[mem_waddr] <= mem_wdata;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wr_state_reg <= SIE_WR_COLLECT;
         rd_state_reg <= SIE_RD_IDLE;
         aw_hold_reg  <= `SIE_RST_BIT;
         w_hold_reg   <= `SIE_RST_BIT;
         wr_addr_reg  <= `SIE_RST_BYTE;
         wr_data_reg  <= 32'h00000000;
         wr_strb_reg  <= 4'h0;
         awready_reg  <= `SIE_RST_BIT;
         wready_reg   <= `SIE_RST_BIT;
         bvalid_reg   <= `SIE_RST_BIT;
         bresp_reg    <= `SIE_RESP_OKAY;
         arready_reg  <= `SIE_RST_BIT;
         rvalid_reg   <= `SIE_RST_BIT;
         rdata_reg    <= 32'h00000000;
         rresp_reg    <= `SIE_RESP_OKAY;
         ext_reg      <= `SIE_RST_BIT;
         instr_reg    <= `SIE_RST_INSTR;
         exec_reg     <= `SIE_RST_BIT;
         acc_reg      <= `SIE_RST_BYTE;
         bank_reg     <= '0;
         index_reg    <= '0;
         mem_addr_reg <= '0;
         c_reg        <= `SIE_RST_BIT;
         dc_reg       <= `SIE_RST_BIT;
         z_reg        <= `SIE_RST_BIT;
         ov_reg       <= `SIE_RST_BIT;
         n_reg        <= `SIE_RST_BIT;
         ill_reg      <= `SIE_RST_BIT;
      end else begin
         wr_state_reg <= wr_state_next;
         rd_state_reg <= rd_state_next;
         aw_hold_reg  <= aw_hold_next;
         w_hold_reg   <= w_hold_next;
         wr_addr_reg  <= wr_addr_next;
         wr_data_reg  <= wr_data_next;
         wr_strb_reg  <= wr_strb_next;
         awready_reg  <= awready_next;
         wready_reg   <= wready_next;
         bvalid_reg   <= bvalid_next;
         bresp_reg    <= bresp_next;
         arready_reg  <= arready_next;
         rvalid_reg   <= rvalid_next;
         rdata_reg    <= rdata_next;
         rresp_reg    <= rresp_next;
         ext_reg      <= ext_next;
         instr_reg    <= instr_next;
         exec_reg     <= exec_next;
         acc_reg      <= acc_next;
         bank_reg     <= bank_next;
         index_reg    <= index_next;
         mem_addr_reg <= mem_addr_next;
         c_reg        <= c_next;
         dc_reg       <= dc_next;
         z_reg        <= z_next;
         ov_reg       <= ov_next;
         n_reg        <= n_next;
         ill_reg      <= ill_next;
      end
   end

   assign s_axi_awready = awready_reg;
   assign s_axi_wready  = wready_reg;
   assign s_axi_bvalid  = bvalid_reg;
   assign s_axi_bresp   = bresp_reg;
   assign s_axi_arready = arready_reg;
   assign s_axi_rvalid  = rvalid_reg;
   assign s_axi_rdata   = rdata_reg;
   assign s_axi_rresp   = rresp_reg;

endmodule : sie_top

// file: hw/sie_defines.svh
`ifndef SIE_DEFINES_SVH
`define SIE_DEFINES_SVH

// Register byte offsets
`define SIE_OFF_CTRL      8'h00
`define SIE_OFF_INSTR     8'h04
`define SIE_OFF_ACC       8'h08
`define SIE_OFF_BANK      8'h0c
`define SIE_OFF_STATUS    8'h10
`define SIE_OFF_INDEX     8'h14
`define SIE_OFF_MEM_ADDR  8'h18
`define SIE_OFF_MEM_DATA  8'h1c

// Field positions
`define SIE_CTRL_EXT_BIT  0
`define SIE_ST_C_BIT      0
`define SIE_ST_DC_BIT     1
`define SIE_ST_Z_BIT      2
`define SIE_ST_OV_BIT     3
`define SIE_ST_N_BIT      4
`define SIE_ST_ILL_BIT    5

// Opcode patterns
`define SIE_LIT_HI        8'h08
`define SIE_FILE_SUB_HI   6'h17
`define SIE_REV_SUBB_HI   6'h15
`define SIE_IDX_LIMIT     8'h5f

// Reset values
`define SIE_RST_BYTE      8'h00
`define SIE_RST_INSTR     16'h0000
`define SIE_RST_BIT       1'b0

// Bus responses
`define SIE_RESP_OKAY     2'b00
`define SIE_RESP_SLVERR   2'b10

`endif

// file: hw/sie_pkg.sv
package sie_pkg;

   typedef enum logic [3:0] {
      SIE_OP_NONE                           = 4'b0001,
      SIE_LITERAL_MINUS_ACCUMULATOR_OP      = 4'b0010,
      SIE_FILE_MINUS_ACCUMULATOR_OP         = 4'b0100,
      SIE_REVERSE_SUBTRACT_WITH_BORROW_OP   = 4'b1000
   } sie_op_t;

   typedef enum logic [1:0] {
      SIE_WR_COLLECT = 2'b01,
      SIE_WR_RESP    = 2'b10
   } sie_wr_state_t;

   typedef enum logic [1:0] {
      SIE_RD_IDLE = 2'b01,
      SIE_RD_RESP = 2'b10
   } sie_rd_state_t;

endpackage : sie_pkg

// file: hw/sie_decode.sv
`timescale 1ns/1ps
`include "sie_defines.svh"

module sie_decode import sie_pkg::*; #(
   parameter int BANK_W = 4
) (
   // Instruction and context
   input  wire logic [15:0]       instr,
   input  wire logic              ext_en,
   input  wire logic [BANK_W-1:0] bank_pointer,
   input  wire logic [BANK_W+7:0] index_ptr,
   // Decoded fields
   output sie_op_t                op,
   output logic                   to_file,
   output logic [BANK_W+7:0]      file_addr
);

   logic [7:0] f;

   assign f = instr[7:0];

   always_comb begin
      op = SIE_OP_NONE;
      if (instr[15:8] == `SIE_LIT_HI) begin
         op = SIE_LITERAL_MINUS_ACCUMULATOR_OP;
      end else if (instr[15:10] == `SIE_FILE_SUB_HI) begin
         op = SIE_FILE_MINUS_ACCUMULATOR_OP;
      end else if (instr[15:10] == `SIE_REV_SUBB_HI) begin
         op = SIE_REVERSE_SUBTRACT_WITH_BORROW_OP;
      end
      // Literal form never targets a file register
      to_file = (op == SIE_FILE_MINUS_ACCUMULATOR_OP ||
                 op == SIE_REVERSE_SUBTRACT_WITH_BORROW_OP) && instr[9];
      if (instr[8]) begin
         file_addr = {bank_pointer, f};
      end else if (f <= `SIE_IDX_LIMIT) begin
         if (ext_en) begin
            file_addr = index_ptr + {{BANK_W{1'b0}}, f};
         end else begin
            file_addr = {{BANK_W{1'b0}}, f};
         end
      end else begin
         file_addr = {{BANK_W{1'b1}}, f};
      end
   end

endmodule : sie_decode

// file: hw/sie_alu.sv
`timescale 1ns/1ps

module sie_alu (
   // Operands
   input  wire logic [7:0] minuend,
   input  wire logic [7:0] subtrahend,
   input  wire logic       borrow_in,
   // Result and flags
   output logic [7:0]      diff,
   output logic            carry,
   output logic            half_carry_flag,
   output logic            zero,
   output logic            signed_wrap_flag,
   output logic            negative
);

   function automatic logic [8:0] sub_borrow(input logic [7:0] a,
                                             input logic [7:0] b,
                                             input logic       bin);
      sub_borrow = {1'b0, a} - {1'b0, b} - {8'h00, bin};
   endfunction : sub_borrow

   logic [8:0] full;
   logic [8:0] low;

   assign full = sub_borrow(minuend, subtrahend, borrow_in);
   assign low  = sub_borrow({4'h0, minuend[3:0]}, {4'h0, subtrahend[3:0]}, borrow_in);
   assign diff = full[7:0];
   assign carry = ~full[8];
   assign zero = (full[7:0] == 8'h00);
   assign negative = full[7];
   assign half_carry_flag = ~low[8];
   assign signed_wrap_flag = (minuend[7] != subtrahend[7]) && (full[7] != minuend[7]);

endmodule : sie_alu

// file: test/sie_top_properties.sv
`timescale 1ns/1ps
module sie_top_properties #(
   parameter int AXI_AW = 8
) (
   // Clock and reset
   input wire logic              aclk,
   input wire logic              aresetn,
   // Write side
   input wire logic              s_axi_awvalid,
   input wire logic              s_axi_awready,
   input wire logic              s_axi_wvalid,
   input wire logic              s_axi_wready,
   input wire logic [1:0]        s_axi_bresp,
   input wire logic              s_axi_bvalid,
   input wire logic              s_axi_bready,
   // Read side
   input wire logic [AXI_AW-1:0] s_axi_araddr,
   input wire logic              s_axi_arvalid,
   input wire logic              s_axi_arready,
   input wire logic [31:0]       s_axi_rdata,
   input wire logic [1:0]        s_axi_rresp,
   input wire logic              s_axi_rvalid,
   input wire logic              s_axi_rready
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   AST_B_AFTER_AW: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
      && s_axi_wready |=> ##1 s_axi_bvalid) else $error("no write response");
   AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
      && $stable(s_axi_bresp)) else $error("write response dropped");
   AST_WR_BLOCKED: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write accepted while response pending");
   AST_B_DONE: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid
      && s_axi_awready && s_axi_wready) else $error("write channel not freed");
   AST_B_CAUSE: assert property ($rose(s_axi_bvalid) |-> $past(!s_axi_awready
      && !s_axi_wready)) else $error("response without request");
   AST_R_AFTER_AR: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid
      && !s_axi_arready) else $error("no read data");
   AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
      && $stable(s_axi_rdata)) else $error("read data dropped");
   AST_R_DONE: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid
      && s_axi_arready) else $error("read channel not freed");
   AST_R_UNMAPPED: assert property (s_axi_arvalid && s_axi_arready
      && s_axi_araddr[7:0] > 8'h1c |=> s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0)
      else $error("unmapped read answered");
   COV_WR: cover property (s_axi_bvalid && s_axi_bready);
   COV_RD: cover property (s_axi_rvalid && s_axi_rready);
   COV_ERR: cover property (s_axi_rvalid && s_axi_rresp == 2'b10);
endmodule : sie_top_properties

bind sie_top sie_top_properties #(.AXI_AW(AXI_AW)) u_sie_top_properties (
   .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
   .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
   .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

// file: test/tb_subtract_instruction_exec.sv
`timescale 1ns/1ps
module tb_subtract_instruction_exec;
   logic        aclk = 1'b0;
   logic        aresetn = 1'b0;
   logic [7:0]  awaddr = 8'h00;
   logic [7:0]  araddr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic        awvalid = 1'b0;
   logic        wvalid = 1'b0;
   logic        arvalid = 1'b0;
   logic        bready = 1'b0;
   logic        rready = 1'b0;
   logic        slow = 1'b0;
   logic        awready, wready, bvalid, arready, rvalid;
   logic [31:0] rdata;
   logic [1:0]  bresp, rresp, resp;
   int          err_total = 0;
   int          n_compared = 0;
   int          seed = 32'h3528;
   always #4 aclk = ~aclk;
   sie_top u_sie_top (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready));
   task automatic wrap_up;
      if (err_total == 0 && n_compared > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : wrap_up
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic tick(inout int n);
      @(posedge aclk);
      n++;
      if (n > 64) begin
         chk(32'h1, 32'h0);
         wrap_up();
      end
   endtask : tick
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= !slow;
      do begin
         tick(n);
         if (awready)
            awvalid <= 1'b0;
         if (wready)
            wvalid <= 1'b0;
         if (bvalid && !bready)
            bready <= 1'b1;
      end while (!(bvalid && bready));
      resp = bresp;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      int n;
      n = 0;
      araddr <= a;
      arvalid <= 1'b1;
      rready <= !slow;
      do begin
         tick(n);
         if (arready)
            arvalid <= 1'b0;
         if (rvalid && !rready)
            rready <= 1'b1;
      end while (!(rvalid && rready));
      d = rdata;
      resp = rresp;
   endtask : rd
   // Result and flags {diff, N, OV, Z, DC, C}
   function automatic logic [12:0] ref_sub(input logic [7:0] m, s, input logic bin);
      logic [8:0] t;
      logic [4:0] h;
      t = {1'b0, m} + {1'b0, ~s} + {8'h0, ~bin};
      h = {1'b0, m[3:0]} + {1'b0, ~s[3:0]} + {4'h0, ~bin};
      return {t[7:0], t[7], (m[7] ^ s[7]) & (t[7] ^ m[7]), t[7:0] == 8'h0, h[4], t[8]};
   endfunction : ref_sub
   initial begin
      logic [31:0] v;
      logic [15:0] ins;
      logic [12:0] e;
      logic [11:0] ad, ix;
      logic [7:0]  k, w, fv, f, res;
      logic [4:0]  st;
      logic [3:0]  bk;
      logic [1:0]  op;
      logic        d, a, x;
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      rd(8'h20, v);
      chk({v[29:0], resp}, 32'h2);
      wr(8'h24, 32'h1);
      chk({30'h0, resp}, 32'h2);
      for (int i = 0; i < 48; i++) begin
         {f, fv, w, k} = $random(seed);
         {slow, bk, ix, st, x, a, d, op} = 27'($random(seed));
         if (i == 0) {op, k, w} = {2'd0, 8'h02, 8'h03};
         if (i == 1) {op, d, fv, w} = {2'd1, 1'b1, 8'h01, 8'h02};
         if (i == 2) {op, d, fv, w, st[0]} = {2'd2, 1'b1, 8'h01, 8'h02, 1'b0};
         if (i == 3) {op, a, x, f} = {2'd1, 1'b0, 1'b1, 8'h5f};
         if (i == 4) {op, a, x, f} = {2'd2, 1'b0, 1'b1, 8'h60};
         ad = a ? {bk, f} : (f > 8'h5f) ? {4'hf, f} : x ? ix + {4'h0, f} : {4'h0, f};
         ins = op == 0 ? {8'h08, k} : {4'h5, op == 1 ? 2'b11 : op == 2 ? 2'b01 : 2'b10, d, a, f};
         e = op == 0 ? ref_sub(k, w, 1'b0) : op == 1 ? ref_sub(fv, w, 1'b0) : ref_sub(w, fv, ~st[0]);
         res = e[12:5];
         wr(8'h00, {31'h0, x});
         wr(8'h0c, {28'h0, bk});
         wr(8'h14, {20'h0, ix});
         wr(8'h08, {24'h0, w});
         wr(8'h10, {26'h1, st});
         wr(8'h18, {20'h0, ad});
         wr(8'h1c, {24'h0, fv});
         wr(8'h04, {16'h0, ins});
         rd(8'h08, v);
         chk(v, {24'h0, (op == 0 || (op != 3 && !d)) ? res : w});
         rd(8'h10, v);
         chk(v, op == 3 ? {26'h1, st} : {27'h0, e[4:0]});
         rd(8'h1c, v);
         chk(v, {24'h0, (op == 1 || op == 2) && d ? res : fv});
      end
      wrap_up();
   end
endmodule : tb_subtract_instruction_exec
